// >>> src/rgag_top.sv
// Register region address generator: turns region descriptors into per-channel byte addresses.
// Assumes an APB master on pclk and a register file port that accepts one address a cycle.
//
// The implementer's own choices: register access over APB and the register offsets.

`default_nettype none

module rgag_top #(
   parameter int CHAN_MAX = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output rgag_pkg::rgag_chan_type chan_out,
   output logic busy
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [2:0] elem_size(input logic [2:0] t);
      case (t)
         3'h0, 3'h1: elem_size = rgag_pkg::ESIZE_BYTE;
         3'h2, 3'h3: elem_size = rgag_pkg::ESIZE_WORD;
         default: elem_size = rgag_pkg::ESIZE_OTHER;
      endcase
   endfunction : elem_size

   function automatic logic [15:0] scale(input logic [7:0] n, input logic [2:0] es);
      scale = 16'(n) * 16'(es);
   endfunction : scale

   function automatic logic [10:0] reg_of(input logic [15:0] a, input logic big);
      reg_of = big ? 11'(a >> rgag_pkg::SHIFT_512) : 11'(a >> rgag_pkg::SHIFT_256);
   endfunction : reg_of

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [31:0] ctrl;
   logic [31:0] region;
   logic [31:0] step;
   logic [15:0] imm;
   logic [15:0] areg [CHAN_MAX];
   logic done;
   logic [7:0] gather;
   logic [7:0] emitted;

   wire logic setup = psel & ~penable;
   wire logic wr_acc = psel & penable & pwrite;
   wire logic hit_areg = (paddr >= rgag_pkg::OFF_AREG) && (paddr <= rgag_pkg::AREG_END);
   wire logic [4:0] areg_sel = 5'((paddr - rgag_pkg::OFF_AREG) >> 2);
   wire logic hit = hit_areg || paddr == rgag_pkg::OFF_CTRL || paddr == rgag_pkg::OFF_REGION
                    || paddr == rgag_pkg::OFF_STEP || paddr == rgag_pkg::OFF_IMM
                    || paddr == rgag_pkg::OFF_STATUS;
   wire logic start_wr = wr_acc && hit && paddr == rgag_pkg::OFF_CTRL
                         && pwdata[rgag_pkg::CTRL_START];

   // Descriptor fields as the instruction carries them.
   wire logic big = ctrl[rgag_pkg::CTRL_REG512];
   wire rgag_pkg::rgag_mode_type mode =
      rgag_pkg::rgag_mode_type'(ctrl[rgag_pkg::CTRL_MODE_LO +: 2]);
   wire logic is_dst = ctrl[rgag_pkg::CTRL_DST];
   wire logic reduce = ctrl[rgag_pkg::CTRL_REDUCE];
   // The start write carries the new control word, so the origin must follow it, not ctrl.
   wire logic start_big = pwdata[rgag_pkg::CTRL_REG512];
   wire rgag_pkg::rgag_mode_type start_mode =
      rgag_pkg::rgag_mode_type'(pwdata[rgag_pkg::CTRL_MODE_LO +: 2]);
   wire logic [7:0] reg_idx = region[rgag_pkg::RGN_REG_LO +: 8];
   wire logic [4:0] sub_idx = region[rgag_pkg::RGN_SUB_LO +: 5];
   wire logic [2:0] esz = elem_size(region[rgag_pkg::RGN_TYPE_LO +: 3]);
   wire logic [2:0] exec_log = region[rgag_pkg::RGN_EXEC_LO +: 3];
   wire logic [2:0] width_log = region[rgag_pkg::RGN_WIDTH_LO +: 3];
   wire logic [15:0] h_bytes = scale(8'(step[rgag_pkg::STEP_H_LO +: 6]), esz);
   wire logic [15:0] v_bytes = scale(8'(step[rgag_pkg::STEP_V_LO +: 6]), esz);

   // Sizing: one element per channel, destination is one row, reduction halves it.
   wire logic [2:0] cnt_log = (is_dst && reduce && exec_log != 3'h0) ?
                              exec_log - 3'h1 : exec_log;
   wire logic [2:0] row_log = is_dst ? cnt_log :
                              (mode == rgag_pkg::RGAG_PER_ELEMENT) ? 3'h0 : width_log;
   wire logic [7:0] count = 8'h01 << cnt_log;
   wire logic [7:0] row_len = 8'h01 << row_log;
   wire logic [7:0] rows = 8'(count >> row_log);

   // Origins: direct from fields, indirect from address register plus offset.
   wire logic [15:0] direct_org = (start_big ? 16'(reg_idx) << rgag_pkg::SHIFT_512
                                       : 16'(reg_idx) << rgag_pkg::SHIFT_256)
                                  + scale(8'(sub_idx), esz);
   wire logic [15:0] start_org = (start_mode == rgag_pkg::RGAG_DIRECT) ? direct_org
                                 : areg[0] + imm;

   // ------------------------------------------------------------------
   // Region walk
   // ------------------------------------------------------------------
   typedef enum logic {
      RGAG_IDLE,
      RGAG_RUN
   } rgag_state_type;

   rgag_state_type state;
   logic [7:0] x;
   logic [7:0] y;
   logic [4:0] chan;
   logic [15:0] row_base;
   logic [15:0] offset;
   logic [10:0] last_reg;
   logic first;

   wire logic row_end = (x == row_len - 8'h01);
   wire logic walk_end = (8'(chan) == count - 8'h01);
   wire logic [4:0] next_row = 5'(y + 8'h01);
   wire logic [15:0] cur_addr = (mode == rgag_pkg::RGAG_PER_ELEMENT && !is_dst) ?
                                areg[chan] + imm : offset;
   wire logic [15:0] next_row_base = (mode == rgag_pkg::RGAG_PER_ROW && !is_dst) ?
                                     areg[next_row] + imm
                                     : row_base + v_bytes;
   wire logic new_reg = first || reg_of(cur_addr, big) != last_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= RGAG_IDLE;
         x <= 8'h00;
         y <= 8'h00;
         chan <= 5'h00;
         row_base <= 16'h0000;
         offset <= 16'h0000;
         last_reg <= 11'h000;
         first <= 1'b0;
         chan_out <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         gather <= 8'h00;
         emitted <= 8'h00;
      end else begin
         chan_out <= '0;
         case (state)
            RGAG_IDLE: begin
               if (start_wr) begin
                  state <= RGAG_RUN;
                  busy <= 1'b1;
                  done <= 1'b0;
                  x <= 8'h00;
                  y <= 8'h00;
                  chan <= 5'h00;
                  row_base <= start_org;
                  offset <= start_org;
                  first <= 1'b1;
                  gather <= 8'h00;
                  emitted <= 8'h00;
               end
            end
            RGAG_RUN: begin
               chan_out.valid <= 1'b1;
               chan_out.last <= walk_end;
               chan_out.chan <= chan;
               chan_out.addr <= cur_addr;
               emitted <= emitted + 8'h01;
               first <= 1'b0;
               last_reg <= reg_of(cur_addr, big);
               if (new_reg) begin
                  gather <= gather + 8'h01;
               end
               chan <= chan + 5'h01;
               if (row_end) begin
                  x <= 8'h00;
                  y <= y + 8'h01;
                  row_base <= next_row_base;
                  offset <= next_row_base;
               end else begin
                  x <= x + 8'h01;
                  offset <= offset + h_bytes;
               end
               if (walk_end) begin
                  state <= RGAG_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            default: state <= RGAG_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   wire logic [31:0] status = {8'h00, emitted, gather, 6'h00, done, busy};
   wire logic [31:0] rd_mux =
      hit_areg ? {16'h0000, areg[areg_sel]} :
      (paddr == rgag_pkg::OFF_CTRL) ? ctrl :
      (paddr == rgag_pkg::OFF_REGION) ? region :
      (paddr == rgag_pkg::OFF_STEP) ? step :
      (paddr == rgag_pkg::OFF_IMM) ? {16'h0000, imm} :
      (paddr == rgag_pkg::OFF_STATUS) ? status : 32'h0000_0000;

   // Descriptors are frozen while a walk runs; writes then are dropped.
   wire logic cfg_wr = wr_acc && hit && state == RGAG_IDLE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= rgag_pkg::CTRL_RESET;
         region <= rgag_pkg::REGION_RESET;
         step <= rgag_pkg::STEP_RESET;
         imm <= 16'h0000;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
         if (cfg_wr && paddr == rgag_pkg::OFF_CTRL) begin
            ctrl <= {pwdata[31:1], 1'b0};
         end
         if (cfg_wr && paddr == rgag_pkg::OFF_REGION) begin
            region <= pwdata;
         end
         if (cfg_wr && paddr == rgag_pkg::OFF_STEP) begin
            step <= pwdata;
         end
         if (cfg_wr && paddr == rgag_pkg::OFF_IMM) begin
            imm <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (cfg_wr && hit_areg) begin
         areg[areg_sel] <= pwdata[15:0];
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_walk_count: assert property (@(posedge pclk) disable iff (!presetn)
      chan_out.valid && chan_out.last |-> 8'(chan_out.chan) == count - 8'h01)
      else $error("walk length differs from element count");

   chk_dst_reduce: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN && is_dst && reduce && exec_log != 3'h0
      |-> count == (8'h01 << exec_log) >> 1)
      else $error("reduction destination not halved");

   chk_row_step: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN && !row_end && mode != rgag_pkg::RGAG_PER_ELEMENT && !walk_end
      |=> chan_out.valid && offset == $past(offset) + $past(h_bytes))
      else $error("element address step wrong");

   chk_row_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN && row_end && mode == rgag_pkg::RGAG_DIRECT && !walk_end
      |=> offset == $past(row_base) + $past(v_bytes) && x == 8'h00)
      else $error("row start step wrong");

   chk_origin_dir: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_IDLE && start_wr && start_mode == rgag_pkg::RGAG_DIRECT && !start_big
      |=> offset == (16'(reg_idx) << rgag_pkg::SHIFT_256) + scale(8'(sub_idx), esz))
      else $error("256-bit origin wrong");

   chk_origin_big: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_IDLE && start_wr && start_mode == rgag_pkg::RGAG_DIRECT && start_big
      |=> offset == (16'(reg_idx) << rgag_pkg::SHIFT_512) + scale(8'(sub_idx), esz))
      else $error("512-bit origin wrong");

   chk_chan_order: assert property (@(posedge pclk) disable iff (!presetn)
      chan_out.valid && !chan_out.last
      |=> chan_out.valid && chan_out.chan == $past(chan_out.chan) + 5'h01)
      else $error("channels not consecutive");

   chk_elem_size: assert property (@(posedge pclk) disable iff (!presetn)
      region[rgag_pkg::RGN_TYPE_LO +: 3] <= 3'h1 |-> esz == 3'h1)
      else $error("byte element size wrong");

   chk_rows: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN && walk_end && mode == rgag_pkg::RGAG_DIRECT && !is_dst
      |-> y == rows - 8'h01)
      else $error("row count wrong");

   chk_indirect: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_IDLE && start_wr && start_mode == rgag_pkg::RGAG_ORIGIN_ONLY
      |=> offset == $past(areg[0]) + $past(imm))
      else $error("indirect origin wrong");

   chk_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_IDLE && start_wr |=> busy && state == RGAG_RUN)
      else $error("walk did not start");

   chk_busy_level: assert property (@(posedge pclk) disable iff (!presetn)
      busy == (state == RGAG_RUN))
      else $error("busy does not follow the walk");

   chk_first_chan: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_IDLE && start_wr |-> ##2 chan_out.valid && chan_out.chan == 5'h00)
      else $error("first channel is not channel zero");

   chk_run_valid: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN |=> chan_out.valid)
      else $error("channel missing during walk");

   chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !busy && !chan_out.valid |=> !chan_out.valid)
      else $error("channel issued while idle");

   chk_last_done: assert property (@(posedge pclk) disable iff (!presetn)
      chan_out.valid && chan_out.last |-> done && !busy && emitted == count)
      else $error("walk end not reported");

   chk_dst_row: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN && is_dst |-> row_len == count)
      else $error("destination is not one row");

   chk_rows_bound: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN |-> y < rows)
      else $error("row index beyond row count");

   chk_elem_wide: assert property (@(posedge pclk) disable iff (!presetn)
      region[rgag_pkg::RGN_TYPE_LO +: 3] >= 3'h2
      |-> esz == (region[rgag_pkg::RGN_TYPE_LO + 2] ? rgag_pkg::ESIZE_OTHER
                                                     : rgag_pkg::ESIZE_WORD))
      else $error("wide element size wrong");

   chk_pe_addr: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN && mode == rgag_pkg::RGAG_PER_ELEMENT && !is_dst
      |=> chan_out.addr == $past(areg[chan]) + $past(imm))
      else $error("per element address wrong");

   chk_row_index: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN && row_end && !walk_end && mode == rgag_pkg::RGAG_PER_ROW && !is_dst
      |=> offset == $past(areg[5'(y + 8'h01)]) + $past(imm))
      else $error("per row start wrong");

   chk_cfg_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_RUN |=> $stable(ctrl) && $stable(region) && $stable(step) && $stable(imm))
      else $error("descriptor changed during walk");

   chk_gather_first: assert property (@(posedge pclk) disable iff (!presetn)
      state == RGAG_IDLE && start_wr |-> ##2 gather == 8'h01)
      else $error("first register not counted");

   chk_gather_bound: assert property (@(posedge pclk) disable iff (!presetn)
      gather <= emitted)
      else $error("more registers than channels");

endmodule : rgag_top

`default_nettype wire

// >>> src/rgag_pkg.sv
// Constants, register map and carrier types of the register region address generator.
// Assumes an APB master with 32-bit data and byte addresses on the register side.
//
// Contract
// - Every operand region is sized from execution width, one element per channel.
// - Destination count equals execution width, halved for integer reduction operations.
// - A source region is a 2D array walked row by row, elements within rows.
// - Vertical step may be at or below horizontal step, so rows may overlap.
// - Element size is one byte for bytes, two for words, four otherwise.
// - Row count of a source region is execution width divided by row width.
// - Subregister counts elements; width and steps count elements; register index whole registers.
// - With 256-bit registers the origin is index shifted by five plus subregister bytes.
// - With 512-bit registers the origin is index shifted by six plus subregister bytes.
// - Within a row channels are consecutive, address grows by horizontal step bytes.
// - After each row the row start grows by vertical step bytes.
// - A destination is one row of execution width elements with horizontal step only.
// - A source spanning several registers takes extra gather cycles, possibly above two; here the walk only counts them in gather.
// - Direct addressing takes every region parameter from the instruction fields.
// - Indirect addressing supplies origin only, each row start, or each element position.
// - Indirect address is a 16-bit address register plus immediate byte offset.

`default_nettype none

package rgag_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_REGION = 8'h04;
   localparam logic [7:0] OFF_STEP = 8'h08;
   localparam logic [7:0] OFF_IMM = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_AREG = 8'h80;
   localparam logic [7:0] AREG_END = 8'hfc;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_REG512 = 1;
   localparam int CTRL_MODE_LO = 2;
   localparam int CTRL_DST = 4;
   localparam int CTRL_REDUCE = 5;
   localparam int RGN_REG_LO = 0;
   localparam int RGN_SUB_LO = 8;
   localparam int RGN_TYPE_LO = 13;
   localparam int RGN_EXEC_LO = 16;
   localparam int RGN_WIDTH_LO = 19;
   localparam int STEP_H_LO = 0;
   localparam int STEP_V_LO = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_GATHER_LO = 8;
   localparam int STAT_COUNT_LO = 16;

   // ------------------------------------------------------------------
   // Reset values and geometry
   // ------------------------------------------------------------------
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] REGION_RESET = 32'h0000_0000;
   localparam logic [31:0] STEP_RESET = 32'h0000_0101;
   localparam int SHIFT_256 = 5;
   localparam int SHIFT_512 = 6;
   localparam logic [2:0] ESIZE_BYTE = 3'h1;
   localparam logic [2:0] ESIZE_WORD = 3'h2;
   localparam logic [2:0] ESIZE_OTHER = 3'h4;

   typedef enum logic [1:0] {
      RGAG_DIRECT,
      RGAG_ORIGIN_ONLY,
      RGAG_PER_ROW,
      RGAG_PER_ELEMENT
   } rgag_mode_type;

   typedef enum logic [2:0] {
      RGAG_UB, RGAG_B, RGAG_UW, RGAG_W, RGAG_UD, RGAG_D, RGAG_F, RGAG_V
   } rgag_dtype_type;

   // One channel address toward the register file port.
   typedef struct packed {
      logic valid;
      logic last;
      logic [4:0] chan;
      logic [15:0] addr;
   } rgag_chan_type;

endpackage : rgag_pkg

`default_nettype wire

// >>> verif/rgag_rf_model.sv
// Read port model of the general register file facing the address generator.
// Assumes one channel address a cycle on pclk; it answers each one a cycle later.

`default_nettype none

module rgag_rf_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire rgag_pkg::rgag_chan_type req,
   output rgag_pkg::rgag_chan_type seen
);
   timeunit 1ns;
   timeprecision 1ps;

   // Each accepted address is echoed with its channel so the bench can judge the walk order.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen <= '0;
      end else begin
         seen <= req;
      end
   end
endmodule : rgag_rf_model

`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench of the register region address generator.
// Assumes the design package and the register file port model are compiled first.

`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   rgag_pkg::rgag_chan_type chan_out;
   rgag_pkg::rgag_chan_type rf_seen;
   rgag_pkg::rgag_chan_type exp_q[$];
   logic [15:0] areg [32];
   logic [7:0] ra [5] = '{rgag_pkg::OFF_CTRL, rgag_pkg::OFF_REGION, rgag_pkg::OFF_STEP,
                          rgag_pkg::OFF_IMM, rgag_pkg::OFF_STATUS};
   logic [31:0] rv [5] = '{rgag_pkg::CTRL_RESET, rgag_pkg::REGION_RESET,
                           rgag_pkg::STEP_RESET, 32'h0000_0000, 32'h0000_0000};
   int error_cnt = 0;
   int check_count = 0;
   int seed = 36964;
   int cyc = 0;
   logic [31:0] rd;
   logic [31:0] r;
   logic [31:0] s;
   logic err;
   int el;
   int wl;

   always #2 pclk = ~pclk;

   rgag_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan_out(chan_out), .busy(busy));
   rgag_rf_model u_rf (.pclk(pclk), .presetn(presetn), .req(chan_out), .seen(rf_seen));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic test_done;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Notes the expected channel stream, starts the walk and waits for it to finish.
   task automatic run(input logic [1:0] md, input logic r5, input logic ds, input logic rq,
                      input logic poke, input logic [31:0] rg, input logic [31:0] st,
                      input logic [15:0] imm);
      int es, cnt, w, o, g, sh;
      logic [15:0] pr;
      logic [15:0] row;
      logic [15:0] a;
      es = (rg[15:13] < 3'h2) ? 1 : (rg[15:13] < 3'h4) ? 2 : 4;
      cnt = 1 << rg[18:16];
      w = ds ? cnt : 1 << rg[21:19];
      if (ds && rq) cnt = cnt >> 1;
      o = (int'(rg[7:0]) << (r5 ? 6 : 5)) + int'(rg[12:8]) * es;
      if (md != 2'h0) o = int'(areg[0]) + int'(imm);
      g = 0;
      sh = r5 ? 6 : 5;
      for (int c = 0; c < cnt; c++) begin
         row = (md == 2'h2 && !ds) ? areg[c / w] + imm : 16'(o + (c / w) * st[13:8] * es);
         a = (md == 2'h3 && !ds) ? areg[c] + imm : 16'(row + (c % w) * st[5:0] * es);
         exp_q.push_back('{valid: 1'b1, last: (c == cnt - 1), chan: 5'(c), addr: a});
         if (c == 0 || (a >> sh) != pr) g++;
         pr = a >> sh;
      end
      apb(1'b1, rgag_pkg::OFF_REGION, rg, rd, err);
      apb(1'b1, rgag_pkg::OFF_STEP, st, rd, err);
      apb(1'b1, rgag_pkg::OFF_IMM, {16'h0000, imm}, rd, err);
      apb(1'b1, rgag_pkg::OFF_CTRL, {26'h0, rq, ds, md, r5, 1'b1}, rd, err);
      if (poke) begin
         apb(1'b1, rgag_pkg::OFF_REGION, ~rg, rd, err);
         apb(1'b1, rgag_pkg::OFF_CTRL, 32'h0000_0001, rd, err);
      end
      repeat (2) @(posedge pclk);
      while (busy !== 1'b0) begin
         @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
      check(32'(exp_q.size()), 32'h0, "channels missing");
      apb(1'b0, rgag_pkg::OFF_STATUS, 32'h0, rd, err);
      check(rd & 32'h00ff_ff03, {8'h00, 8'(cnt), 8'(g), 6'h0, 2'b10}, "status");
      if (poke) begin
         apb(1'b0, rgag_pkg::OFF_REGION, 32'h0, rd, err);
         check(rd, rg, "region written while busy");
      end
   endtask : run

   // ------------------------------------------------------------------
   // Output watcher and hang limit
   // ------------------------------------------------------------------
   always @(posedge pclk) begin
      if (rf_seen.valid === 1'b1) begin
         if (exp_q.size() == 0) check(32'h1, 32'h0, "unexpected channel");
         else check(32'(rf_seen), 32'(exp_q.pop_front()), "channel");
      end
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         test_done();
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      for (int i = 0; i < 32; i++) areg[i] = 16'h0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ra[i], 32'h0, rd, err);
         check(rd, rv[i], "reset value");
         check({31'h0, err}, 32'h0, "error on mapped read");
      end
      apb(1'b0, 8'h40, 32'h0, rd, err);
      check({31'h0, err}, 32'h1, "unmapped read error");
      check(rd, 32'h0, "unmapped read data");
      apb(1'b1, rgag_pkg::OFF_STATUS, 32'hffff_ffff, rd, err);
      apb(1'b0, rgag_pkg::OFF_STATUS, 32'h0, rd, err);
      check(rd, 32'h0, "status is read only");
      for (int i = 0; i < 32; i++) begin
         r = $random(seed);
         areg[i] = r[15:0];
         apb(1'b1, 8'(rgag_pkg::OFF_AREG + 4 * i), r, rd, err);
      end
      apb(1'b0, 8'h94, 32'h0, rd, err);
      check(rd, {16'h0000, areg[5]}, "address register");
      for (int t = 0; t < 8; t++) begin
         for (int m = 0; m < 8; m++) begin
            r = $random(seed);
            s = $random(seed);
            el = int'(r[18:16]) % 6;
            wl = int'(r[21:19]) % (el + 1);
            run(2'(m), m[2], 1'b0, 1'b0, 1'b0,
                {10'h0, 3'(wl), 3'(el), 3'(t), r[12:8], r[7:0]},
                {18'h0, s[13:8], 2'h0, s[5:0]}, s[31:16]);
         end
      end
      run(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, {10'h0, 3'd3, 3'd4, 3'd3, 5'd0, 8'd5},
          {18'h0, 6'd1, 2'h0, 6'd2}, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         run({1'b0, m[0]}, 1'b0, 1'b1, m[1], 1'b0, {10'h0, 3'd0, 3'd4, 3'd2, 5'd0, 8'd7},
             {18'h0, 6'd9, 2'h0, 6'd1}, 16'(16'h00e0 - areg[0]));
      end
      run(2'h0, 1'b1, 1'b0, 1'b0, 1'b1, {10'h0, 3'd2, 3'd4, 3'd5, 5'd1, 8'd3},
          {18'h0, 6'd0, 2'h0, 6'd1}, 16'h0000);
      test_done();
   end
endmodule : tb_top

`default_nettype wire
